// [hdl/dtoc_pkg.sv]
// register map, field positions and reset values of the dual timer output compare block
package dtoc_pkg;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] OFS_TMODE  = 8'h10;
   localparam logic [7:0] OFS_CSS    = 8'h14;
   localparam logic [7:0] OFS_PTR    = 8'h18;
   localparam logic [7:0] OFS_CMP_LO = 8'h1C;
   localparam logic [7:0] OFS_CMP_HI = 8'h20;
   localparam logic [7:0] OFS_RELOAD = 8'h24;
   localparam logic [7:0] OFS_PORT   = 8'h28;
   localparam logic [7:0] OFS_TSRC   = 8'h2C;
   localparam logic [7:0] OFS_OMODE  = 8'h30;
   localparam logic [7:0] OFS_OSTAT  = 8'h34;
   localparam logic [7:0] OFS_ISRC   = 8'h38;
   localparam logic [7:0] OFS_IREQ   = 8'h3C;
   // first_timer_low_byte, second_timer_low_byte and the matching high bytes
   localparam logic [7:0] OFS_T_LO [2] = '{8'h00, 8'h08};
   localparam logic [7:0] OFS_T_HI [2] = '{8'h04, 8'h0C};

   // ==========================================
   // field positions
   localparam int TMODE_STOP_LSB = 0;   // bit t: timer t stopped
   localparam int TMODE_WCTL_LSB = 2;   // bit 2+t: timer t writes latch only
   localparam int CSS_W          = 3;
   localparam int CSS_LSB [2]    = '{0, 4};
   localparam int OMODE_TEN_LSB  = 0;   // trigger enables, one per channel
   localparam int OMODE_LVL_LSB  = 4;   // output level latches
   localparam int OMODE_MOD_LSB  = 8;   // modulation enables, one per pair
   localparam int IREQ_CMP_LSB   = 2;   // bits 0,1 timer underflow requests

   // ==========================================
   // count source codes
   localparam logic [2:0] SRC_ALT = 3'h6;  // on-chip osc (first) / first underflow (second)
   localparam logic [7:0] DIV_MASK [6] = '{8'h01, 8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'hFF};

   // ==========================================
   // reset values and bus answers
   localparam logic [15:0] RST_TIMER = 16'hFFFF;
   localparam logic [15:0] RST_LATCH = 16'hFFFF;
   localparam logic [3:0]  RST_TMODE = 4'h3;    // both timers stopped
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : dtoc_pkg

// [hdl/dtoc_timer.sv]
// one reloadable down-counting timer with reload latch
`timescale 1ns/1ns
`default_nettype none
module dtoc_timer
   import dtoc_pkg::*;
#(
   parameter int TW = 16
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ce,
   input  wire logic          tick,
   input  wire logic          stop,
   input  wire logic          wr_en,
   input  wire logic          wr_latch_only,
   input  wire logic [TW-1:0] wr_val,
   output logic      [TW-1:0] count_r,
   output logic      [TW-1:0] latch_r,
   output logic      [TW-1:0] cnt_nxt,
   output logic               step,
   output logic               uf
);
   if (TW != 16) begin : g_chk
      $error("dtoc_timer: only 16-bit timers are supported");
   end

   assign step    = tick & ~stop;
   assign uf      = step & (count_r == '0);
   // reload after zero gives n+1 division
   assign cnt_nxt = uf ? latch_r : count_r - 1'b1;

   // reload latch, written whatever the run state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_r <= RST_LATCH;
      end else if (ce && wr_en) begin
         latch_r <= wr_val;
      end
   end

   // counter; a write with latch-only set leaves it alone even when stopped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= RST_TIMER;
      end else if (ce) begin
         if (wr_en && !wr_latch_only) begin
            count_r <= wr_val;
         end else if (step) begin
            count_r <= cnt_nxt;
         end
      end
   end
endmodule : dtoc_timer
`default_nettype wire

// [hdl/dtoc_top.sv]
// dual 16-bit timer with four output compare channels behind an axi4-lite slave
//
// Operation
// - timers count down, reload and request on underflow
// - first timer clock: main osc divisions or on-chip
// - second timer clock: divisions or first underflow
// - loaded value n divides by n+1
// - write control: latch only or latch and counter
// - timer byte reads return count, low byte as frozen at the high byte read
// - four channels, each picks a source timer
// - pointer selects channel for compare byte writes
// - reload bit loads latch at source underflow
// - count equal to latch triggers compare
// - trigger enable gates output changes
// - level latch chooses polarity of latch edges
// - output status bit shows channel level
// - per-latch source bit gates compare request
// - modulation ands pair onto even pin
// - stopped source timer loads latch at once
// - latch above reload value never matches
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
module dtoc_top
   import dtoc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int PRE_W  = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   input  wire logic              onchip_osc_clk,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [3:0]             cmp_pin,
   output logic [3:0]             cmp_pin_oe,
   output logic [9:0]             irq_req
);
   if (ADDR_W < 8 || PRE_W < 8) begin : g_chk
      $error("dtoc_top: address and prescaler need at least 8 bits");
   end

   // ==========================================
   // axi4-lite slave
   logic [ADDR_W-1:0] awaddr_r;
   logic              aw_got_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              w_got_r;
   logic              wr_go;
   logic              wr_ok;
   logic [7:0]        wa;
   logic              rd_take;
   logic [31:0]       rd_word;
   logic              rd_ok;

   assign s_axi_awready = ~aw_got_r;
   assign s_axi_wready  = ~w_got_r;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go         = aw_got_r & w_got_r & ~s_axi_bvalid;
   assign wa            = awaddr_r[7:0];
   assign rd_take       = s_axi_arvalid & s_axi_arready;
   // misaligned or out-of-map addresses answer slverr and change nothing
   assign wr_ok         = (awaddr_r >> 6) == '0 && wa[1:0] == 2'b00;

   // address and data are caught independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_got_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_got_r <= 1'b0;
         end
      end
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read data registered at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // byte-lane write strobes; only lanes 0 and 1 carry fields
   function automatic logic wsel(input logic [7:0] ofs, input logic lane);
      wsel = wr_go & wr_ok & (wa == ofs) & lane;
   endfunction : wsel

   // ==========================================
   // control registers
   logic [3:0]  tmode_r;
   logic [7:0]  css_r;
   logic [1:0]  ptr_r;
   logic [3:0]  port_r;
   logic [3:0]  tsrc_r;
   logic [9:0]  omode_r;
   logic [7:0]  isrc_r;

   // plain software-written fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmode_r <= RST_TMODE;
         css_r   <= 8'h00;
         ptr_r   <= 2'h0;
         port_r  <= 4'h0;
         tsrc_r  <= 4'h0;
         omode_r <= 10'h000;
         isrc_r  <= 8'h00;
      end else if (ce) begin
         if (wsel(OFS_TMODE, wstrb_r[0])) tmode_r <= wdata_r[3:0];
         if (wsel(OFS_CSS, wstrb_r[0]))   css_r   <= wdata_r[7:0];
         if (wsel(OFS_PTR, wstrb_r[0]))   ptr_r   <= wdata_r[1:0];
         if (wsel(OFS_PORT, wstrb_r[0]))  port_r  <= wdata_r[3:0];
         if (wsel(OFS_TSRC, wstrb_r[0]))  tsrc_r  <= wdata_r[3:0];
         if (wsel(OFS_OMODE, wstrb_r[0])) omode_r[7:0] <= wdata_r[7:0];
         if (wsel(OFS_OMODE, wstrb_r[1])) omode_r[9:8] <= wdata_r[9:8];
         if (wsel(OFS_ISRC, wstrb_r[0]))  isrc_r  <= wdata_r[7:0];
      end
   end

   // ==========================================
   // count sources
   logic [PRE_W-1:0] pre_r;
   logic             osc_d_r;
   logic             osc_rise;

   // free divider of the main oscillator (aclk) feeding all division taps
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r   <= '0;
         osc_d_r <= 1'b0;
      end else if (ce) begin
         pre_r   <= pre_r + 1'b1;
         osc_d_r <= onchip_osc_clk;
      end
   end
   assign osc_rise = onchip_osc_clk & ~osc_d_r;

   // ==========================================
   // the two timers
   logic [15:0] cnt     [2];
   logic [15:0] tlatch  [2];
   logic [15:0] cnt_nxt [2];
   logic [1:0]  step;
   logic [1:0]  uf;
   logic [1:0]  alt;
   logic [7:0]  stage_r [2];
   logic [7:0]  rdlo_r  [2];

   // second timer can cascade from first underflow
   assign alt = {uf[0], osc_rise};

   for (genvar t = 0; t < 2; t++) begin : g_tmr
      logic [2:0] sel;
      logic       tick;
      logic       commit;
      assign sel = css_r[CSS_LSB[t] +: CSS_W];
      assign tick = (sel == SRC_ALT) ? alt[t] :
                    (sel < SRC_ALT) && ((pre_r[7:0] & DIV_MASK[sel]) == DIV_MASK[sel]);
      // the high byte write commits the 16-bit value staged by the low byte
      assign commit = wsel(OFS_T_HI[t], wstrb_r[0]);

      dtoc_timer #(.TW(16)) u_tmr (
         .aclk          (aclk),
         .aresetn       (aresetn),
         .ce            (ce),
         .tick          (tick),
         .stop          (tmode_r[TMODE_STOP_LSB + t]),
         .wr_en         (commit),
         .wr_latch_only (tmode_r[TMODE_WCTL_LSB + t]),
         .wr_val        ({wdata_r[7:0], stage_r[t]}),
         .count_r       (cnt[t]),
         .latch_r       (tlatch[t]),
         .cnt_nxt       (cnt_nxt[t]),
         .step          (step[t]),
         .uf            (uf[t])
      );

      // low byte staging and read snapshot keep both halves coherent
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            stage_r[t] <= 8'h00;
            rdlo_r[t]  <= 8'h00;
         end else if (ce) begin
            if (wsel(OFS_T_LO[t], wstrb_r[0])) stage_r[t] <= wdata_r[7:0];
            // high byte read freezes live low byte
            if (rd_take && s_axi_araddr[7:0] == OFS_T_HI[t]) rdlo_r[t] <= cnt[t][7:0];
         end
      end
   end

   // ==========================================
   // compare registers and latches
   logic [15:0] cmp_reg [4];
   logic [15:0] latch   [8];
   logic [7:0]  reload_r;
   logic [7:0]  xfer;
   logic [7:0]  hit;

   // compare register of the pointed channel, low byte then high byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_reg <= '{default: RST_LATCH};
      end else if (ce) begin
         if (wsel(OFS_CMP_LO, wstrb_r[0])) cmp_reg[ptr_r][7:0]  <= wdata_r[7:0];
         if (wsel(OFS_CMP_HI, wstrb_r[0])) cmp_reg[ptr_r][15:8] <= wdata_r[7:0];
      end
   end

   for (genvar j = 0; j < 8; j++) begin : g_lat
      localparam int CH = j / 2;
      logic src;
      assign src = tsrc_r[CH];
      // or happens at once while stopped
      assign xfer[j] = reload_r[j] & (uf[src] | tmode_r[TMODE_STOP_LSB + int'(src)]);
      // equality on the new count value
      // latch above reload value is ignored
      assign hit[j] = step[src] & (cnt_nxt[src] == latch[j]) & (latch[j] <= tlatch[src]);

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            latch[j] <= RST_LATCH;
         end else if (ce && xfer[j]) begin
            latch[j] <= cmp_reg[CH];
         end
      end
   end

   // reload bits: software sets, transfer clears; a new set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_r <= 8'h00;
      end else if (ce) begin
         reload_r <= (reload_r & ~xfer) | (wsel(OFS_RELOAD, wstrb_r[0]) ? wdata_r[7:0] : 8'h00);
      end
   end

   // ==========================================
   // request bits, write one to clear, set beats clear
   logic [9:0] ireq_set;
   logic [9:0] ireq_clr;

   assign ireq_set = {hit & isrc_r, uf};
   assign ireq_clr = {wsel(OFS_IREQ, wstrb_r[1]) ? wdata_r[9:8] : 2'b00,
                      wsel(OFS_IREQ, wstrb_r[0]) ? wdata_r[7:0] : 8'h00};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_req <= 10'h000;
      end else if (ce) begin
         irq_req <= (irq_req & ~ireq_clr) | ireq_set;
      end
   end

   // ==========================================
   // waveform per channel
   logic [3:0] raw_r;
   logic [3:0] lvl;
   logic [3:0] wave;

   for (genvar c = 0; c < 4; c++) begin : g_ch
      assign lvl[c] = raw_r[c] ^ omode_r[OMODE_LVL_LSB + c];

      // x0 match raises, x1 match drops; x0 wins if both land together
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            raw_r[c] <= 1'b0;
         end else if (ce) begin
            if (omode_r[OMODE_TEN_LSB + c] && hit[2*c]) begin
               raw_r[c] <= 1'b1;
            end else if (omode_r[OMODE_TEN_LSB + c] && hit[2*c+1]) begin
               raw_r[c] <= 1'b0;
            end
         end
      end

      if (c % 2 == 0) begin : g_even
         // even pin carries and of pair
         assign wave[c] = omode_r[OMODE_MOD_LSB + c/2] ? (lvl[c] & lvl[c+1]) : lvl[c];
      end else begin : g_odd
         assign wave[c] = lvl[c];
      end

      // pin only driven while its port bit is set
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cmp_pin[c] <= 1'b0;
         end else if (ce) begin
            cmp_pin[c] <= port_r[c] & wave[c];
         end
      end
   end
   assign cmp_pin_oe = port_r;

   // ==========================================
   // read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = (s_axi_araddr >> 6) == '0 && s_axi_araddr[1:0] == 2'b00;
      case (s_axi_araddr[7:0])
         OFS_T_HI[0]: rd_word[7:0] = cnt[0][15:8];
         OFS_T_LO[0]: rd_word[7:0] = rdlo_r[0];
         OFS_T_HI[1]: rd_word[7:0] = cnt[1][15:8];
         OFS_T_LO[1]: rd_word[7:0] = rdlo_r[1];
         OFS_TMODE:   rd_word[3:0] = tmode_r;
         OFS_CSS:     rd_word[7:0] = css_r;
         OFS_PTR:     rd_word[1:0] = ptr_r;
         OFS_CMP_LO:  rd_word[7:0] = cmp_reg[ptr_r][7:0];
         OFS_CMP_HI:  rd_word[7:0] = cmp_reg[ptr_r][15:8];
         OFS_RELOAD:  rd_word[7:0] = reload_r;
         OFS_PORT:    rd_word[3:0] = port_r;
         OFS_TSRC:    rd_word[3:0] = tsrc_r;
         OFS_OMODE:   rd_word[9:0] = omode_r;
         OFS_OSTAT:   rd_word[3:0] = lvl;
         OFS_ISRC:    rd_word[7:0] = isrc_r;
         OFS_IREQ:    rd_word[9:0] = irq_req;
         default:     rd_ok = 1'b0;
      endcase
   end
endmodule : dtoc_top
`default_nettype wire

// [tb/dtoc_top_properties.sv]
// port-level assertions for the dual timer output compare block
`timescale 1ns/1ns
`default_nettype none
module dtoc_top_properties
   import dtoc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
   ,
   input wire logic [3:0]  cmp_pin,
   input wire logic [3:0]  cmp_pin_oe,
   input wire logic [9:0]  irq_req
);
   // ==========================================
   // single clock domain, reset mutes everything but the reset check
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // bus answers arrive in time and hold until taken
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while read pending");
   // outputs quiet one edge after reset seen
   a_reset_out: assert property (disable iff (1'b0) !aresetn |=> irq_req == 10'h000 && cmp_pin == 4'h0)
      else $error("outputs not cleared by reset");
   a_pin_gate: assert property ((cmp_pin & ~cmp_pin_oe & ~$past(cmp_pin_oe)) == 4'h0)
      else $error("pin driven while port disabled");
   a_irq_clear: assert property (|($past(irq_req) & ~irq_req) |-> !$past(s_axi_awready))
      else $error("request bit fell without a write");
   a_oe_write: assert property (cmp_pin_oe != $past(cmp_pin_oe) |-> !$past(s_axi_awready))
      else $error("port enable changed without a write");

   // main scenarios reached
   c_second_uf: cover property ($rose(irq_req[1]));
   c_pin_fall: cover property ($fell(cmp_pin[0]));
   c_bad_addr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : dtoc_top_properties

bind dtoc_top dtoc_top_properties #(.ADDR_W(ADDR_W)) dtoc_top_properties_i (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_pin, .cmp_pin_oe, .irq_req);
`default_nettype wire

// [tb/dtoc_pin_sink.sv]
// external load on the compare pins: pull-down when released, edge counter on pin a
`timescale 1ns/1ns
`default_nettype none
module dtoc_pin_sink (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  pin,
   input  wire logic [3:0]  oe,
   output logic      [3:0]  lvl,
   output logic      [15:0] rise_cnt_r
);
   logic prev_r;
   // ==========================================
   // released pins fall to the pull-down level
   assign lvl = oe & pin;
   // count rising edges on modulation pin a
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r     <= 1'b0;
         rise_cnt_r <= 16'h0000;
      end else begin
         prev_r <= lvl[0];
         if (lvl[0] && !prev_r) rise_cnt_r <= rise_cnt_r + 16'h0001;
      end
   end
endmodule : dtoc_pin_sink
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the dual timer output compare block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dtoc_pkg::*;
   logic        aclk = 0, aresetn = 0, osc = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rdata;
   logic        awr, wrdy, bv, arr, rv;
   logic [1:0]  bresp, rresp;
   logic [3:0]  pin, oe, lvl;
   logic [9:0]  irq;
   logic [15:0] rises;
   int          fail_count = 0, compares = 0, cyc = 0, osc_n = 0;

   // ==========================================
   // clock, cycle count and a slow on-chip oscillator (rise every 6 cycles)
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc   <= cyc + 1;
      osc_n <= (osc_n == 2) ? 0 : osc_n + 1;
      if (osc_n == 2) osc <= ~osc;
   end

   dtoc_top dtoc_top_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .onchip_osc_clk(osc),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .cmp_pin(pin), .cmp_pin_oe(oe), .irq_req(irq));
   dtoc_pin_sink dtoc_pin_sink_i (.aclk(aclk), .aresetn(aresetn), .pin(pin), .oe(oe), .lvl(lvl),
      .rise_cnt_r(rises));

   // ==========================================
   // comparison and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   // ==========================================
   // bus master: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      br  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!(awr && wrdy) && n < 99);
      awv <= 1'b0;
      wv  <= 1'b0;
      while (!bv && n < 99) begin
         @(posedge aclk);
         n++;
      end
      br <= 1'b0;
      // a write that never answers is a mismatch, not a silent pass
      if (n >= 99) fail_count++;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rr  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!arr && n < 99);
      arv <= 1'b0;
      while (!rv && n < 99) begin
         @(posedge aclk);
         n++;
      end
      d = rdata;
      r = rresp;
      rr <= 1'b0;
      if (n >= 99) fail_count++;
   endtask : rd

   // ==========================================
   // helpers: timer setup, compare load, waits
   task automatic tmr(input int t, input logic [31:0] css, input logic [15:0] n, input logic [31:0] run);
      // both timers stopped around any access
      wr(OFS_TMODE, 32'h3);
      wr(OFS_CSS, css);
      wr(OFS_T_LO[t], {24'h0, n[7:0]});
      wr(OFS_T_HI[t], {24'h0, n[15:8]});
      wr(OFS_TMODE, run);
   endtask : tmr
   task automatic cmp(input int j, input logic [7:0] v);
      // pointer, low, high, then reload bit
      wr(OFS_PTR, 32'(j / 2));
      wr(OFS_CMP_LO, {24'h0, v});
      wr(OFS_CMP_HI, 32'h0);
      wr(OFS_RELOAD, 32'h1 << j);
   endtask : cmp
   task automatic wirq(input int b, output int t);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (irq[b] !== 1'b1 && n < 3000);
      t = cyc;
   endtask : wirq
   // the first clear may collide with an underflow, so only the last gap counts
   task automatic period(input int b, input int e);
      int t0, t1;
      t1 = 0;
      for (int i = 0; i < 3; i++) begin
         t0 = t1;
         wr(OFS_IREQ, 32'h1 << b);
         wirq(b, t1);
      end
      check(t1 - t0, e);
   endtask : period
   task automatic wlvl(input logic v);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (lvl[0] !== v && n < 200);
   endtask : wlvl
   task automatic hiw(input int e);
      int t0;
      wlvl(1'b0);
      wlvl(1'b1);
      t0 = cyc;
      wlvl(1'b0);
      check(cyc - t0, e);
   endtask : hiw

   // ==========================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          t;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_TMODE, d, r);
      check(d, {28'h0, RST_TMODE});
      rd(8'h40, d, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      // live count reads and latch-only writes on a stopped timer
      wr(OFS_T_LO[0], 32'h34);
      wr(OFS_T_HI[0], 32'h12);
      rd(OFS_T_HI[0], d, r);
      check(d, 32'h12);
      rd(OFS_T_LO[0], d, r);
      check(d, 32'h34);
      wr(OFS_TMODE, 32'h7);
      wr(OFS_T_LO[0], 32'h78);
      wr(OFS_T_HI[0], 32'h56);
      rd(OFS_T_HI[0], d, r);
      check(d, 32'h12);
      // every division, the on-chip clock and the cascade
      for (int k = 0; k < 6; k++) begin
         tmr(0, 32'(k), 16'h3, 32'h2);
         period(0, 4 * (DIV_MASK[k] + 1));
      end
      tmr(0, 32'h6, 16'h3, 32'h2);
      period(0, 24);
      tmr(1, 32'h60, 16'h1, 32'h0);
      period(1, 16);
      // channel 0 on the first timer: rise at 7, fall at 4, reload 9
      tmr(0, 32'h0, 16'h9, 32'h3);
      cmp(0, 8'h7);
      cmp(1, 8'h4);
      rd(OFS_RELOAD, d, r);
      check(d, 32'h0);
      wr(OFS_PORT, 32'h1);
      wr(OFS_ISRC, 32'h1);
      wr(OFS_OMODE, 32'h1);
      wr(OFS_TMODE, 32'h2);
      hiw(6);
      check({30'h0, irq[3:2]}, 32'h1);
      wr(OFS_OMODE, 32'h11);
      hiw(14);
      // trigger off: pin frozen, requests still raised
      wr(OFS_OMODE, 32'h10);
      wr(OFS_IREQ, 32'h4);
      repeat (4) @(posedge aclk);
      t = rises;
      repeat (60) @(posedge aclk);
      check(rises, t);
      check({31'h0, irq[2]}, 32'h1);
      rd(OFS_OSTAT, d, r);
      check(d[0], pin[0]);
      // latch above the reload value never matches
      wr(OFS_OMODE, 32'h1);
      wr(OFS_ISRC, 32'h2);
      cmp(1, 8'hC);
      repeat (60) @(posedge aclk);
      wr(OFS_IREQ, 32'hC);
      repeat (45) @(posedge aclk);
      check({31'h0, pin[0]}, 32'h1);
      check({30'h0, irq[3:2]}, 32'h0);
      // modulation pair: pin a is channel 0 and channel 1
      // cascade second timer, even on first, odd on second
      tmr(1, 32'h60, 16'h1, 32'h3);
      cmp(1, 8'h4);
      wr(OFS_TSRC, 32'h2);
      wr(OFS_OMODE, 32'h101);
      wr(OFS_TMODE, 32'h0);
      t = rises;
      repeat (60) @(posedge aclk);
      check(rises, t);
      wr(OFS_OMODE, 32'h121);
      hiw(6);
      close_out();
   end

   // cut a hang short far beyond the expected run of about seven thousand cycles
   initial begin
      #1_000_000;
      fail_count++;
      close_out();
   end
endmodule : tb
`default_nettype wire
